// ### src/lpog_ctrl.sv
// low-power off switcher mode selection and power gate drive control
// assumes power state and sequencer slots come from logic on core_clk;
// standby pins, strap and 32 kHz clock are asynchronous pins
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`default_nettype none
module lpog_ctrl
  import lpog_pkg::*;
#(
  parameter int NUM_SW = 4,
  parameter int STRAP_W = 2
) (
  input wire logic core_clk, // 100 MHz core clock
  input wire logic arst_n, // async reset, active low
  input wire logic clk32kPin, // 32 kHz timing clock pin
  input wire logic standbyPin, // primary standby, decoded polarity
  input wire logic secondary_standby_pin, // secondary standby, decoded polarity
  input wire logic [STRAP_W-1:0] powerup_mode_strap, // power-up strap pins
  input wire lpog_pstate_t powerState, // current power state
  input wire logic [NUM_SW-1:0] seqSlot, // one-cycle sequencer slot per switcher
  output logic gate_drive_out_a, // gate drive a, high closes switch
  output logic gate_drive_out_b, // gate drive b
  output logic chargePumpEn, // gate drive charge pump enable
  output lpog_sweff_t [NUM_SW-1:0] swDrive, // effective mode and set point
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  // pin synchronisers, first stage read only by second
  logic [2:0] s1_q, s1_d, s2_q, s2_d;
  logic clk32Dly_q;
  logic [STRAP_W-1:0] strap1_q, strap2_q;
  always_comb begin
    s1_d = {clk32kPin, standbyPin, secondary_standby_pin};
    s2_d = s1_q;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      clk32Dly_q <= 1'b0;
      strap1_q <= '0;
      strap2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      clk32Dly_q <= s2_q[2];
      strap1_q <= powerup_mode_strap;
      strap2_q <= strap1_q;
    end
  end
  logic tick;
  assign tick = s2_q[2] & ~clk32Dly_q; // rising edge of slow clock

  // state groups
  logic swCtl, lpoState;
  assign swCtl = (powerState == PS_WATCHDOG) || (powerState == PS_ON) ||
                 (powerState == PS_USEROFF_WAIT);
  assign lpoState = (powerState == PS_USEROFF) || (powerState == PS_MEMHOLD) ||
                    (powerState == PS_MEMHOLD_CUT);

  // standby entry delay
  logic stbyEff_q, stbyEff_d;
  logic [1:0] stbyCnt_q, stbyCnt_d;
  logic [1:0] dly_q, dly_d;
  logic stbyRaw;
  assign stbyRaw = s2_q[1] & s2_q[0] & (powerState == PS_ON); // R1
  always_comb begin
    stbyEff_d = stbyEff_q;
    stbyCnt_d = stbyCnt_q;
    if (!stbyRaw) begin
      stbyEff_d = 1'b0; // R17
      stbyCnt_d = 2'h0;
    end else if (!stbyEff_q) begin
      if (stbyCnt_q >= dly_q) begin
        stbyEff_d = 1'b1; // R17
      end else if (tick) begin
        stbyCnt_d = stbyCnt_q + 2'h1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stbyEff_q <= 1'b0;
      stbyCnt_q <= 2'h0;
    end else begin
      stbyEff_q <= stbyEff_d;
      stbyCnt_q <= stbyCnt_d;
    end
  end

  // register file and axi slave
  lpog_swcfg_t [NUM_SW-1:0] cfg_q, cfg_d;
  logic enA_q, enA_d, enB_q, enB_d;
  logic [1:0] initCnt_q, initCnt_d;
  logic awRdy_q, awRdy_d, wRdy_q, wRdy_d, bVal_q, bVal_d, arRdy_q, arRdy_d, rVal_q, rVal_d;
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d, rData_q, rData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
  logic [31:0] statWord;
  lpog_sweff_t [NUM_SW-1:0] eff_q, eff_d;
  logic gateA_q, gateA_d, gateB_q, gateB_d, cp_q, cp_d;
  assign statWord = {26'h0, stbyEff_q, cp_q, gateB_q, gateA_q, enB_q, enA_q};

  always_comb begin
    logic [31:0] ctrlWord;
    logic [31:0] nw;
    logic hit;
    ctrlWord = {28'h0, dly_q, enB_q, enA_q};
    nw = 32'h0;
    hit = 1'b0;
    cfg_d = cfg_q;
    enA_d = enA_q;
    enB_d = enB_q;
    dly_d = dly_q;
    initCnt_d = initCnt_q;
    awRdy_d = awRdy_q;
    wRdy_d = wRdy_q;
    bVal_d = bVal_q;
    arRdy_d = arRdy_q;
    rVal_d = rVal_q;
    awHeld_d = awHeld_q;
    wHeld_d = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bResp_d = bResp_q;
    rData_d = rData_q;
    rResp_d = rResp_q;
    if (initCnt_q != LPOG_INIT_CYCLES) begin
      // load normal and standby alike from the strap
      initCnt_d = initCnt_q + 2'h1;
      for (int i = 0; i < NUM_SW; i++) begin
        cfg_d[i].modeField = LPOG_POWERUP_MODE_STRAP_MODE; // R3
        cfg_d[i].normalSetpt = LPOG_POWERUP_MODE_STRAP_SETPT[strap2_q];
        cfg_d[i].standbySetpt = LPOG_POWERUP_MODE_STRAP_SETPT[strap2_q]; // R3
        cfg_d[i].memholdMode = 1'b0;
        cfg_d[i].useroffMode = 1'b0;
      end
      if (initCnt_d == LPOG_INIT_CYCLES) begin
        awRdy_d = 1'b1;
        wRdy_d = 1'b1;
        arRdy_d = 1'b1;
      end
    end else begin
      if (s_axi_awvalid && awRdy_q) begin
        awAddr_d = s_axi_awaddr;
        awHeld_d = 1'b1;
        awRdy_d = 1'b0;
      end
      if (s_axi_wvalid && wRdy_q) begin
        wData_d = s_axi_wdata;
        wStrb_d = s_axi_wstrb;
        wHeld_d = 1'b1;
        wRdy_d = 1'b0;
      end
      if (awHeld_q && wHeld_q && !bVal_q) begin
        awHeld_d = 1'b0;
        wHeld_d = 1'b0;
        bVal_d = 1'b1;
        if (awAddr_q == LPOG_CTRL_OFS) begin
          nw = lpog_merge(ctrlWord, wData_q, wStrb_q);
          enA_d = nw[LPOG_CTRL_ENA_BIT]; // R13
          enB_d = nw[LPOG_CTRL_ENB_BIT];
          dly_d = nw[LPOG_CTRL_DLY_LSB +: 2];
          hit = 1'b1;
        end else if (awAddr_q == LPOG_STAT_OFS) begin
          hit = 1'b1; // read-only, write ignored
        end
        for (int i = 0; i < NUM_SW; i++) begin
          if (awAddr_q == LPOG_SWCFG_OFS + 8'(4 * i)) begin
            nw = lpog_merge({16'h0, cfg_q[i]}, wData_q, wStrb_q);
            cfg_d[i] = nw[15:0];
            hit = 1'b1;
          end else if (awAddr_q == LPOG_SWEFF_OFS + 8'(4 * i)) begin
            hit = 1'b1;
          end
        end
        bResp_d = hit ? LPOG_RESP_OKAY : LPOG_RESP_DECERR;
      end
      if (bVal_q && s_axi_bready) begin
        bVal_d = 1'b0;
        awRdy_d = 1'b1;
        wRdy_d = 1'b1;
      end
      if (s_axi_arvalid && arRdy_q) begin
        arRdy_d = 1'b0;
        rVal_d = 1'b1;
        rData_d = 32'h0;
        rResp_d = LPOG_RESP_DECERR;
        if (s_axi_araddr == LPOG_CTRL_OFS) begin
          rData_d = ctrlWord;
          rResp_d = LPOG_RESP_OKAY;
        end else if (s_axi_araddr == LPOG_STAT_OFS) begin
          rData_d = statWord;
          rResp_d = LPOG_RESP_OKAY;
        end
        for (int i = 0; i < NUM_SW; i++) begin
          if (s_axi_araddr == LPOG_SWCFG_OFS + 8'(4 * i)) begin
            rData_d = {16'h0, cfg_q[i]}; // R4
            rResp_d = LPOG_RESP_OKAY;
          end else if (s_axi_araddr == LPOG_SWEFF_OFS + 8'(4 * i)) begin
            rData_d = {24'h0, eff_q[i]};
            rResp_d = LPOG_RESP_OKAY;
          end
        end
      end
      if (rVal_q && s_axi_rready) begin
        rVal_d = 1'b0;
        arRdy_d = 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= '0;
      enA_q <= 1'b0;
      enB_q <= 1'b0;
      dly_q <= LPOG_DLY_RESET;
      initCnt_q <= 2'h0;
      awRdy_q <= 1'b0;
      wRdy_q <= 1'b0;
      bVal_q <= 1'b0;
      arRdy_q <= 1'b0;
      rVal_q <= 1'b0;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      bResp_q <= LPOG_RESP_OKAY;
      rData_q <= 32'h0;
      rResp_q <= LPOG_RESP_OKAY;
    end else begin
      cfg_q <= cfg_d;
      enA_q <= enA_d;
      enB_q <= enB_d;
      dly_q <= dly_d;
      initCnt_q <= initCnt_d;
      awRdy_q <= awRdy_d;
      wRdy_q <= wRdy_d;
      bVal_q <= bVal_d;
      arRdy_q <= arRdy_d;
      rVal_q <= rVal_d;
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bResp_q <= bResp_d;
      rData_q <= rData_d;
      rResp_q <= rResp_d;
    end
  end

  // per-switcher sequencing and effective drive
  logic [NUM_SW-1:0] hold_q, started_q;
  for (genvar g = 0; g < NUM_SW; g++) begin : gSw
    logic hold_d, started_d;
    logic [4:0] holdSet_q, holdSet_d;
    logic lpoBit;
    assign lpoBit = (powerState == PS_USEROFF) ? cfg_q[g].useroffMode // R9
                                               : cfg_q[g].memholdMode; // R8
    always_comb begin
      hold_d = hold_q[g];
      started_d = started_q[g];
      holdSet_d = holdSet_q;
      eff_d[g] = eff_q[g];
      if (lpoState) begin
        if (started_q[g] && lpoBit) begin
          hold_d = 1'b1;
          holdSet_d = cfg_q[g].standbySetpt; // R5
        end
        started_d = 1'b0; // frozen until next startup R6
      end else if (seqSlot[g]) begin
        hold_d = 1'b0; // reload as from off, never forced off R7
        started_d = 1'b1;
      end else if (powerState == PS_OFF) begin
        hold_d = 1'b0;
        started_d = 1'b0;
      end
      if (tick) begin
        if (hold_q[g]) begin
          eff_d[g] = '{setpt: holdSet_q, mode: BM_PFM}; // R10
        end else if (!started_q[g]) begin
          eff_d[g] = '{setpt: cfg_q[g].normalSetpt, mode: BM_OFF};
        end else if (stbyEff_q) begin
          eff_d[g] = '{setpt: cfg_q[g].standbySetpt, mode: lpog_decode(cfg_q[g].modeField,
                                                                      1'b1)}; // R2
        end else begin
          eff_d[g] = '{setpt: cfg_q[g].normalSetpt, mode: lpog_decode(cfg_q[g].modeField,
                                                                     1'b0)}; // R18
        end
      end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        hold_q[g] <= 1'b0;
        started_q[g] <= 1'b0;
        holdSet_q <= 5'h0;
        eff_q[g] <= '{setpt: 5'h0, mode: BM_OFF};
      end else begin
        hold_q[g] <= hold_d;
        started_q[g] <= started_d;
        holdSet_q <= holdSet_d;
        eff_q[g] <= eff_d[g];
      end
    end
  end

  // gate drives and charge pump, updated on the slow tick
  always_comb begin
    gateA_d = gateA_q;
    gateB_d = gateB_q;
    cp_d = cp_q;
    if (tick) begin
      gateA_d = swCtl & ~enA_q; // R12 R13 R14 R11
      gateB_d = swCtl & ~enB_q; // R12 R13 R14 R11
      cp_d = swCtl & ~(enA_q & enB_q); // R15
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gateA_q <= 1'b0;
      gateB_q <= 1'b0;
      cp_q <= 1'b0;
    end else begin
      gateA_q <= gateA_d;
      gateB_q <= gateB_d;
      cp_q <= cp_d;
    end
  end

  assign gate_drive_out_a = gateA_q;
  assign gate_drive_out_b = gateB_q;
  assign chargePumpEn = cp_q;
  assign swDrive = eff_q;
  assign s_axi_awready = awRdy_q;
  assign s_axi_wready = wRdy_q;
  assign s_axi_bvalid = bVal_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arRdy_q;
  assign s_axi_rvalid = rVal_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  AST_STBY_AND: assert property (stbyEff_q |-> $past(s2_q[1] && s2_q[0])) // R1
    else $error("standby active without both pins");
  AST_STBY_EXIT: assert property (!stbyRaw |=> !stbyEff_q) // R17
    else $error("standby not left at once");
  AST_GATE_LPO: assert property (tick && lpoState |=> !gate_drive_out_a && !gate_drive_out_b) // R11
    else $error("gate drive on in low-power off");
  AST_GATE_LOW: assert property (tick && !swCtl |=> !gate_drive_out_a && !gate_drive_out_b) // R12
    else $error("gate drive on outside software states");
  AST_GATE_SW: assert property (tick && swCtl |=> gate_drive_out_a == !$past(enA_q)) // R13
    else $error("gate a not following enable");
  AST_GATE_POL: assert property (tick && swCtl && enB_q |=> !gate_drive_out_b) // R14
    else $error("gate b enable polarity");
  AST_CP_OFF: assert property (tick && swCtl && enA_q && enB_q |=> !chargePumpEn) // R15
    else $error("charge pump on with both enables");
  AST_HOLD_PFM: assert property (tick && hold_q[0] |=> swDrive[0].mode == BM_PFM) // R10
    else $error("held switcher not in pfm");
  AST_SLOT_NOOFF: assert property (seqSlot[0] && !lpoState |=> !hold_q[0] && started_q[0]) // R7
    else $error("slot did not restart switcher");
  AST_OUT_STABLE: assert property (!tick |=> $stable(gate_drive_out_a)) // R18
    else $error("gate changed off the slow tick");
  COV_STBY: cover property (stbyRaw ##1 !stbyEff_q ##[1:300] stbyEff_q);
  COV_LPO: cover property (hold_q[0] ##[1:300] seqSlot[0]);
  COV_WR: cover property (s_axi_bvalid && s_axi_bready);
endmodule : lpog_ctrl
`default_nettype wire

// ### src/lpog_pkg.sv
// constants, types and helpers of the low-power off switcher and gate control
// assumes one 100 MHz core clock and a 32 kHz timing clock arriving on a pin
//
// Behaviour
// R1: standby for switcher modes is primary AND secondary standby pin
// R2: each switcher has its own standby set point, used while standby holds
// R3: at power-up standby settings equal normal ones, loaded from the strap
// R4: reading a mode field returns the programmed four-bit value only
// R5: a switcher kept on in low-power off runs at its standby set point
// R6: such a switcher holds mode and voltage until the next startup event
// R7: at its sequencer slot a switcher reloads as from off, without turning off
// R8: memory hold: mode bit 0 gives off, 1 gives pulse frequency mode
// R9: user off: mode bit 0 gives off, 1 gives pulse frequency mode
// R10: after turn-on, held switchers stay pulse frequency at standby until slot
// R11: entering low-power off disables both gate drive outputs
// R12: gate drives low in off, starts, user off, memory hold and power cut
// R13: in watchdog, on and user-off-wait each gate follows its enable bit
// R14: under software control enable 1 drives gate low, 0 drives it high
// R15: both enable bits 1 under software control disables the charge pump
// R16: host software closes gate switches by writing enables, in its own order
// R17: standby entry waits 0 to 3 slow ticks; leaving standby is immediate
// R18: gate and switcher outputs are registered on the 32 kHz tick
`default_nettype none
package lpog_pkg;
  // register byte offsets
  localparam logic [7:0] LPOG_CTRL_OFS = 8'h00;
  localparam logic [7:0] LPOG_STAT_OFS = 8'h04;
  localparam logic [7:0] LPOG_SWCFG_OFS = 8'h10;
  localparam logic [7:0] LPOG_SWEFF_OFS = 8'h20;
  // control register fields
  localparam int LPOG_CTRL_ENA_BIT = 0;
  localparam int LPOG_CTRL_ENB_BIT = 1;
  localparam int LPOG_CTRL_DLY_LSB = 2;
  localparam logic [1:0] LPOG_DLY_RESET = 2'h1;
  // axi responses
  localparam logic [1:0] LPOG_RESP_OKAY = 2'h0;
  localparam logic [1:0] LPOG_RESP_DECERR = 2'h3;
  // cycles waited after reset before the strap is trusted
  localparam logic [1:0] LPOG_INIT_CYCLES = 2'h3;
  // strap defaults: mode auto/auto and one set point per strap value
  localparam logic [3:0] LPOG_POWERUP_MODE_STRAP_MODE = 4'h8;
  localparam logic [3:0][4:0] LPOG_POWERUP_MODE_STRAP_SETPT = {5'h1C, 5'h18, 5'h10, 5'h0C};

  typedef enum logic [3:0] {
    PS_OFF, PS_COLD_START, PS_WARM_START, PS_WATCHDOG, PS_ON,
    PS_USEROFF_WAIT, PS_USEROFF, PS_MEMHOLD, PS_MEMHOLD_CUT
  } lpog_pstate_t;

  typedef enum logic [2:0] {BM_OFF, BM_PWM, BM_PWMPS, BM_PFM, BM_AUTO} lpog_bmode_t;

  // programmed per-switcher settings
  typedef struct packed {
    logic useroffMode;          // switcher_useroff_mode_bit
    logic memholdMode;          // switcher_memhold_mode_bit
    logic [4:0] standbySetpt;   // switcher_standby_setpoint
    logic [4:0] normalSetpt;
    logic [3:0] modeField;      // switcher_mode_field
  } lpog_swcfg_t;

  // effective switcher drive
  typedef struct packed {
    logic [4:0] setpt;
    lpog_bmode_t mode;
  } lpog_sweff_t;

  // mode field decode for normal (stby=0) and standby (stby=1)
  function automatic lpog_bmode_t lpog_decode(input logic [3:0] m, input logic stby);
    lpog_bmode_t nrm;
    lpog_bmode_t sby;
    nrm = BM_OFF;
    sby = BM_OFF;
    case (m)
      4'h1: nrm = BM_PWM;
      4'h2: nrm = BM_PWMPS;
      4'h3: nrm = BM_PFM;
      4'h4: nrm = BM_AUTO;
      4'h5: begin nrm = BM_PWM; sby = BM_PWM; end
      4'h6: begin nrm = BM_PWM; sby = BM_AUTO; end
      4'h8: begin nrm = BM_AUTO; sby = BM_AUTO; end
      4'h9: begin nrm = BM_PWM; sby = BM_PWMPS; end
      4'hA: begin nrm = BM_PWMPS; sby = BM_PWMPS; end
      4'hB: begin nrm = BM_PWMPS; sby = BM_AUTO; end
      4'hC: begin nrm = BM_AUTO; sby = BM_PFM; end
      4'hD: begin nrm = BM_PWM; sby = BM_PFM; end
      4'hE: begin nrm = BM_PWMPS; sby = BM_PFM; end
      4'hF: begin nrm = BM_PFM; sby = BM_PFM; end
      default: nrm = BM_OFF;
    endcase
    return stby ? sby : nrm;
  endfunction : lpog_decode

  // byte-lane merge of a write
  function automatic logic [31:0] lpog_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction : lpog_merge
endpackage : lpog_pkg
`default_nettype wire

// ### verification/lpog_gate_model.sv
// external nmos power gate switches sitting on the two gate drive outputs
// assumes gate drive and charge pump enable come registered on core_clk
`default_nettype none
module lpog_gate_model
  import lpog_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic gateA, // gate drive a
  input wire logic gateB, // gate drive b
  input wire logic pumpEn, // gate charge pump enable
  output logic closedA, // switch a conducts
  output logic closedB // switch b conducts
);
  timeunit 1ns;
  timeprecision 1ps;

  // a switch conducts only with a high gate lifted by the charge pump
  always_ff @(posedge core_clk) begin
    closedA <= gateA & pumpEn;
    closedB <= gateB & pumpEn;
  end
endmodule : lpog_gate_model
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench of the low-power off switcher and gate control
// assumes the controller and the gate switch model; one core clock plus the slow pin
`default_nettype none
module tb_top
  import lpog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic clk32kPin = 1'b0;
  logic arst_n, standbyPin, secondary_standby_pin, closedA, closedB, swc;
  logic gate_drive_out_a, gate_drive_out_b, chargePumpEn;
  logic [1:0] powerup_mode_strap, en, s_axi_bresp, s_axi_rresp;
  lpog_pstate_t powerState;
  logic [3:0] seqSlot, s_axi_wstrb;
  lpog_sweff_t [3:0] swDrive;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [4:0] nsp;
  logic [2:0] g;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [33:0] qr[$];
  logic [41:0] qp[$];
  event snap;

  // core clock and slow timing pin, unrelated in phase
  always #5 core_clk = ~core_clk;
  always #15259 clk32kPin = ~clk32kPin;

  lpog_ctrl #(.NUM_SW(4), .STRAP_W(2)) DUT (
    .core_clk(core_clk), .arst_n(arst_n), .clk32kPin(clk32kPin), .standbyPin(standbyPin),
    .secondary_standby_pin(secondary_standby_pin), .powerup_mode_strap(powerup_mode_strap),
    .powerState(powerState), .seqSlot(seqSlot), .gate_drive_out_a(gate_drive_out_a),
    .gate_drive_out_b(gate_drive_out_b), .chargePumpEn(chargePumpEn), .swDrive(swDrive),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  lpog_gate_model farSide (
    .core_clk(core_clk), .gateA(gate_drive_out_a), .gateB(gate_drive_out_b),
    .pumpEn(chargePumpEn), .closedA(closedA), .closedB(closedB)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // axi write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
    logic done;
    done = 1'b0;
    qr.push_back({rsp, 32'h0});
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  // axi read: rready held until rvalid
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    logic done;
    done = 1'b0;
    qr.push_back(exp);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd

  // wait for a slow tick and let the registered outputs settle
  task automatic tick();
    @(posedge clk32kPin);
    repeat (8) @(posedge core_clk);
  endtask : tick

  // one-cycle sequencer slot pulse
  task automatic slot(input logic [3:0] m);
    @(posedge core_clk);
    seqSlot <= m;
    @(posedge core_clk);
    seqSlot <= 4'h0;
  endtask : slot

  // note a masked port snapshot for the port monitor
  task automatic chk(input logic [20:0] m, input logic [20:0] x);
    qp.push_back({m, x});
    ->snap;
  endtask : chk

  // bus monitor: each response taken is compared with the oldest note
  always @(posedge core_clk) begin
    if ((s_axi_rvalid === 1'b1 && s_axi_rready) || (s_axi_bvalid === 1'b1 && s_axi_bready)) begin
      check(s_axi_rvalid === 1'b1 ? {30'h0, s_axi_rresp, s_axi_rdata}
            : {30'h0, s_axi_bresp, 32'h0}, {30'h0, qr.pop_front()});
    end
  end

  // port monitor: gates, switches and two switcher drives under a mask
  always @(snap) begin
    logic [41:0] e;
    e = qp.pop_front();
    check({43'h0, {gate_drive_out_a, gate_drive_out_b, chargePumpEn, closedA, closedB,
           swDrive[1], swDrive[0]} & e[41:21]}, {43'h0, e[20:0] & e[41:21]});
  end

  // watchdog against a hang
  initial begin
    #900000;
    n_mismatch++;
    stop_test();
  end

  // main sequence
  initial begin
    arst_n = 1'b0;
    standbyPin = 1'b0;
    secondary_standby_pin = 1'b0;
    powerup_mode_strap = 2'h2;
    powerState = PS_OFF;
    seqSlot = 4'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    void'($urandom(32'hBF5D));
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(LPOG_SWCFG_OFS, {LPOG_RESP_OKAY, 18'h0, LPOG_POWERUP_MODE_STRAP_SETPT[2], LPOG_POWERUP_MODE_STRAP_SETPT[2],
       LPOG_POWERUP_MODE_STRAP_MODE});
    rd(LPOG_CTRL_OFS, {LPOG_RESP_OKAY, 28'h0, LPOG_DLY_RESET, 2'h0});
    rd(8'h40, {LPOG_RESP_DECERR, 32'h0});
    wr(8'h44, 32'h1, LPOG_RESP_DECERR);
    // every power state with random gate enables, both enables set in on
    for (int s = 0; s < 9; s++) begin
      en = (s == 4) ? 2'h3 : 2'($urandom);
      powerState <= lpog_pstate_t'(s);
      wr(LPOG_CTRL_OFS, {30'h0, en}, LPOG_RESP_OKAY);
      tick();
      swc = (s >= 3 && s <= 5);
      g = {swc & ~en[0], swc & ~en[1], swc & (en != 2'h3)};
      chk(21'h1F0000, {g, g[2] & g[0], g[1] & g[0], 16'h0});
    end
    // program two switchers and start them in normal mode
    powerState <= PS_OFF;
    nsp = 5'($urandom);
    wr(LPOG_SWCFG_OFS, {18'h1, 5'h05, nsp, 4'hC}, LPOG_RESP_OKAY);
    wr(LPOG_SWCFG_OFS + 8'h04, 32'h0000_0F11, LPOG_RESP_OKAY);
    tick();
    powerState <= PS_ON;
    slot(4'h3);
    tick();
    chk(21'h00FFFF, {5'h0, 5'h11, BM_PWM, nsp, BM_AUTO});
    // standby entry with three ticks of delay, exit without delay
    wr(LPOG_CTRL_OFS, 32'h0000_000C, LPOG_RESP_OKAY);
    standbyPin <= 1'b1;
    secondary_standby_pin <= 1'b1;
    tick();
    tick();
    rd(LPOG_STAT_OFS, {LPOG_RESP_OKAY, 32'h0000_001C});
    tick();
    tick();
    rd(LPOG_STAT_OFS, {LPOG_RESP_OKAY, 32'h0000_003C});
    rd(LPOG_SWCFG_OFS, {LPOG_RESP_OKAY, 18'h1, 5'h05, nsp, 4'hC});
    slot(4'h3);
    tick();
    chk(21'h00FFFF, {5'h0, 5'h07, BM_OFF, 5'h05, BM_PFM});
    secondary_standby_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd(LPOG_STAT_OFS, {LPOG_RESP_OKAY, 32'h0000_001C});
    standbyPin <= 1'b0;
    slot(4'h3);
    tick();
    // memory hold, then turn-on keeps the held switcher until its slot
    powerState <= PS_MEMHOLD;
    tick();
    chk(21'h1F07FF, {10'h0, BM_OFF, 5'h05, BM_PFM});
    powerState <= PS_WARM_START;
    tick();
    chk(21'h0000FF, {13'h0, 5'h05, BM_PFM});
    powerState <= PS_ON;
    slot(4'h3);
    tick();
    chk(21'h0000FF, {13'h0, nsp, BM_AUTO});
    // user off keeps only the switcher whose user-off bit is set
    wr(LPOG_SWCFG_OFS + 8'h04, 32'h0000_8F11, LPOG_RESP_OKAY);
    powerState <= PS_USEROFF;
    tick();
    chk(21'h1FFF07, {5'h0, 5'h07, BM_PFM, 5'h0, BM_OFF});
    rd(LPOG_SWEFF_OFS + 8'h04, {LPOG_RESP_OKAY, 24'h0, 5'h07, BM_PFM});
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
